/* src/elsh_params.svh */
/*
 Constants for the extra-lane and sync-header configuration block:
 register offsets, field positions, reset values and codes.
 Assumes inclusion by bare name from the package and the modules.
*/
`ifndef ELSH_PARAMS_SVH
`define ELSH_PARAMS_SVH

// Register offsets on the 12-bit register port
`define ELSH_ADDR_XA         12'h20a
`define ELSH_ADDR_XB         12'h20b
`define ELSH_ADDR_SHM        12'h20f
`define ELSH_ADDR_CTRL       12'h300
`define ELSH_ADDR_STAT       12'h301
// Reset values
`define ELSH_RST_XA          8'h00
`define ELSH_RST_XB          8'h00
`define ELSH_RST_SHM         8'h00
// Field positions
`define ELSH_SER_BIT         0
`define ELSH_SHM_LO          0
`define ELSH_SHM_HI          1
// Sync-header codes
`define ELSH_SHM_CRC         2'h0
`define ELSH_SHM_FEC         2'h2
// Test-pattern codes
`define ELSH_TP_NONE         4'h0
`define ELSH_TP_RAMP         4'h4
`define ELSH_TP_ALT          4'h5
// Lanes per link
`define ELSH_LANES           8
// Stream FIFO shape
`define ELSH_FIFO_W          8
`define ELSH_FIFO_D          16

`endif

/* src/elsh_pkg.sv */
/*
 Types for the extra-lane and sync-header configuration block.
 Assumes the params header is on the include path.
*/
`include "elsh_params.svh"
package elsh_pkg;
   // Per-lane payload choice
   typedef enum logic [1:0] {
      ELSH_PAY_OFF  = 2'b00,
      ELSH_PAY_MODE = 2'b01,
      ELSH_PAY_RAMP = 2'b10
   } elsh_pay_t;
   // Sync-word content
   typedef enum logic [1:0] {
      ELSH_SW_IDLE = 2'b00,
      ELSH_SW_CRC  = 2'b01,
      ELSH_SW_FEC  = 2'b10
   } elsh_sw_t;
endpackage

/* src/elsh_fifo.sv */
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes one clock and an active-low reset already synchronised.
*/
`timescale 1ns/1ps
module elsh_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_sync_b,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   count;
   logic          push;
   logic          pop;

   // Handshake terms
   assign in_ready  = (count != (AW+1)'(D));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers and level
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + AW'(1);
         if (pop)  rd_ptr <= rd_ptr + AW'(1);
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // elsh_fifo

/* src/elsh_lane.sv */
/*
 One lane's enable and payload decision for one link.
 Assumes lower-lane chain input comes from the lane below.
*/
`timescale 1ns/1ps
module elsh_lane
   import elsh_pkg::*;
(
   // Inputs
   input  wire logic      mode_use,
   input  wire logic      extra_bit,
   input  wire logic      ser_bit,
   input  wire logic      powered,
   input  wire logic      ramp_sub,
   input  wire logic      below_ok,
   // Outputs
   output logic           clk_on,
   output logic           ser_on,
   output logic           chain_ok,
   output elsh_pay_t      pay
);
   logic want;
   // Link-layer clock follows mode or extra bit, gated by power
   assign want     = mode_use || extra_bit;
   assign clk_on   = powered && want;
   assign ser_on   = powered && below_ok && (mode_use || (extra_bit && ser_bit));
   assign chain_ok = below_ok && clk_on;
   // Payload choice
   always_comb begin
      if (!ser_on)                         pay = ELSH_PAY_OFF;
      else if (!mode_use && ramp_sub)      pay = ELSH_PAY_RAMP;
      else                                 pay = ELSH_PAY_MODE;
   end
endmodule // elsh_lane

/* src/elsh_top.sv */
/*
 Extra-lane enable and sync-header content configuration for the two links.
 Assumes a plain register port and a downstream lane stream consumer.
*/
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "elsh_params.svh"
// How it works
// R1: link A field bit n, for n from 1 to 7, turns on lane An link clocks.
// R2: link B field bit n, for n from 1 to 7, turns on lane Bn link clocks.
// R3: serializer bit 0 gives clocks only, serializers stay off.
// R4: serializer bit 1 enables serializers of selected extra lanes too.
// R5: software changes these registers only while link is disabled.
// R6: extra lanes follow current mode and test-pattern selections.
// R7: extra-only lane sends octet ramp when pattern is 0 or 5.
// R8: channel power-down wins over extra-lane enables.
// R9: serializer n runs only if lanes 0..n-1 are enabled.
// R10: sync-header field 0 sends CRC-12, 2 sends FEC.
// R11: sync-header choice applies only in 64b/66b modes.
// R12: command fields of the sync word always transmit zeros.
// R13: both channels down shuts every lane off.
// R14: serializer bit with no lane bits adds nothing.
module elsh_top
   import elsh_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Register port
   input  wire logic [11:0] addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [7:0]       rdata,
   // Device context
   input  wire logic        link_enable,
   input  wire logic [1:0]  channel_power_down,
   input  wire logic        mode_is_66b,
   input  wire logic [7:0]  mode_lanes_a,
   input  wire logic [7:0]  mode_lanes_b,
   input  wire logic [3:0]  test_pattern_select,
   // Lane controls
   output logic [7:0]       lane_clk_a,
   output logic [7:0]       lane_ser_a,
   output logic [7:0]       lane_clk_b,
   output logic [7:0]       lane_ser_b,
   output logic [15:0]      lane_ramp,
   output elsh_sw_t         sync_word_sel,
   output logic [3:0]       sync_cmd,
   // Lane stream
   output logic             strm_valid,
   input  wire logic        strm_ready,
   output logic [7:0]       strm_data
);
   logic        rst_meta_b;
   logic        rst_sync_b;
   logic [7:0]  link_a_extra_lane_enable;
   logic [7:0]  link_b_extra_lane_enable;
   logic [7:0]  sync_header_mode_select;
   logic        late_write;
   logic [1:0]  sync_header_content;
   logic        link_a_added_serializer_on;
   logic        link_b_added_serializer_on;
   logic        sub_up;
   logic        ramp_sub;
   logic [7:0]  x_a;
   logic [7:0]  x_b;
   logic [7:0]  ck_a, sr_a, ck_b, sr_b;
   logic [8:0]  ch_a, ch_b;
   elsh_pay_t   pay_a [8];
   elsh_pay_t   pay_b [8];
   logic [15:0] next_ramp;
   elsh_sw_t    next_sw;
   logic        f_in_valid;
   logic        f_in_ready;
   logic        f_out_valid;
   logic [7:0]  f_out_data;
   logic [7:0]  ramp_cnt;

   // Reset release through two flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   // Register writes
   // R5: writes only while disabled
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         link_a_extra_lane_enable <= `ELSH_RST_XA;
         link_b_extra_lane_enable <= `ELSH_RST_XB;
         sync_header_mode_select  <= `ELSH_RST_SHM;
      end else if (wr && !link_enable) begin
         case (addr)
            `ELSH_ADDR_XA:  link_a_extra_lane_enable <= wdata;
            `ELSH_ADDR_XB:  link_b_extra_lane_enable <= wdata;
            `ELSH_ADDR_SHM: sync_header_mode_select  <= wdata;
            default:        ;
         endcase
      end
   end

   // Sticky flag for writes refused while the link runs
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         late_write <= 1'b0;
      end else if (wr && link_enable && (addr == `ELSH_ADDR_XA || addr == `ELSH_ADDR_XB
                   || addr == `ELSH_ADDR_SHM)) begin
         late_write <= 1'b1;
      end else if (wr && addr == `ELSH_ADDR_STAT && wdata[0]) begin
         late_write <= 1'b0;
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            `ELSH_ADDR_XA:   rdata <= link_a_extra_lane_enable;
            `ELSH_ADDR_XB:   rdata <= link_b_extra_lane_enable;
            `ELSH_ADDR_SHM:  rdata <= sync_header_mode_select;
            `ELSH_ADDR_CTRL: rdata <= {6'h0, sub_up, link_enable};
            `ELSH_ADDR_STAT: rdata <= {7'h0, late_write};
            default:         rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // Field decode
   assign link_a_added_serializer_on = link_a_extra_lane_enable[`ELSH_SER_BIT];
   assign link_b_added_serializer_on = link_b_extra_lane_enable[`ELSH_SER_BIT];
   assign sync_header_content = sync_header_mode_select[`ELSH_SHM_HI:`ELSH_SHM_LO];
   // R1: link A lane bits
   assign x_a = {link_a_extra_lane_enable[7:1], 1'b0};
   // R2: link B lane bits
   assign x_b = {link_b_extra_lane_enable[7:1], 1'b0};
   // R8: power-down wins
   // R13: both channels down
   assign sub_up = !(&channel_power_down);
   // R7: ramp substitution test
   assign ramp_sub = (test_pattern_select == `ELSH_TP_NONE) ||
                     (test_pattern_select == `ELSH_TP_ALT);

   // Per-lane decisions, chained upward
   assign ch_a[0] = 1'b1;
   assign ch_b[0] = 1'b1;
   for (genvar n = 0; n < `ELSH_LANES; n++) begin : g_lane
      // R3: clocks only unless serializer bit
      // R4: serializers when bit set
      // R9: lower lanes must be on
      // R14: no lane bits adds nothing
      elsh_lane u_a (
         .mode_use  (mode_lanes_a[n]),
         .extra_bit (x_a[n]),
         .ser_bit   (link_a_added_serializer_on),
         .powered   (sub_up && !channel_power_down[0]),
         .ramp_sub  (ramp_sub),
         .below_ok  (ch_a[n]),
         .clk_on    (ck_a[n]),
         .ser_on    (sr_a[n]),
         .chain_ok  (ch_a[n+1]),
         .pay       (pay_a[n])
      );
      elsh_lane u_b (
         .mode_use  (mode_lanes_b[n]),
         .extra_bit (x_b[n]),
         .ser_bit   (link_b_added_serializer_on),
         .powered   (sub_up && !channel_power_down[1]),
         .ramp_sub  (ramp_sub),
         .below_ok  (ch_b[n]),
         .clk_on    (ck_b[n]),
         .ser_on    (sr_b[n]),
         .chain_ok  (ch_b[n+1]),
         .pay       (pay_b[n])
      );
      // R7: extra-only lane carries ramp
      assign next_ramp[n]   = (pay_a[n] == ELSH_PAY_RAMP);
      assign next_ramp[n+8] = (pay_b[n] == ELSH_PAY_RAMP);
   end

   // Sync-word content
   // R10: CRC-12 or FEC
   // R11: only in 64b/66b modes
   always_comb begin
      if (!mode_is_66b) begin
         next_sw = ELSH_SW_IDLE;
      end else if (sync_header_content == `ELSH_SHM_FEC) begin
         next_sw = ELSH_SW_FEC;
      end else begin
         next_sw = ELSH_SW_CRC;
      end
   end

   // Registered lane controls
   // R6: follow mode and pattern
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         lane_clk_a    <= 8'h00;
         lane_ser_a    <= 8'h00;
         lane_clk_b    <= 8'h00;
         lane_ser_b    <= 8'h00;
         lane_ramp     <= 16'h0000;
         sync_word_sel <= ELSH_SW_IDLE;
      end else begin
         lane_clk_a    <= ck_a;
         lane_ser_a    <= sr_a;
         lane_clk_b    <= ck_b;
         lane_ser_b    <= sr_b;
         lane_ramp     <= next_ramp;
         sync_word_sel <= next_sw;
      end
   end

   // R12: command fields idle
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         sync_cmd <= 4'h0;
      end else begin
         sync_cmd <= 4'h0;
      end
   end

   // Octet ramp source into the FIFO while any lane ramps
   assign f_in_valid = |lane_ramp;
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         ramp_cnt <= 8'h00;
      end else if (f_in_valid && f_in_ready) begin
         ramp_cnt <= ramp_cnt + 8'h01;
      end
   end

   elsh_fifo #(.W(`ELSH_FIFO_W), .D(`ELSH_FIFO_D)) u_fifo (
      .clk        (clk),
      .rst_sync_b (rst_sync_b),
      .in_valid   (f_in_valid),
      .in_ready   (f_in_ready),
      .in_data    (ramp_cnt),
      .out_valid  (f_out_valid),
      .out_ready  (strm_ready || !strm_valid),
      .out_data   (f_out_data)
   );

   // Output stage of the stream
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         strm_valid <= 1'b0;
         strm_data  <= 8'h00;
      end else if (strm_ready || !strm_valid) begin
         strm_valid <= f_out_valid;
         strm_data  <= f_out_data;
      end
   end

   // Checks
   property p_ramp_sel;
      @(posedge clk) disable iff (!rst_sync_b)
      (mode_lanes_a[3] == 1'b0 && sr_a[3] && ramp_sub) |=> lane_ramp[3];
   endproperty
   a_ramp_sel: assert property (p_ramp_sel) else $error("ramp not chosen"); // R7

   property p_pd;
      @(posedge clk) disable iff (!rst_sync_b)
      (&channel_power_down) |=> (lane_clk_a == 8'h00 && lane_clk_b == 8'h00);
   endproperty
   a_pd: assert property (p_pd) else $error("lanes on while powered down"); // R13

   property p_clk_only;
      @(posedge clk) disable iff (!rst_sync_b)
      (!link_a_added_serializer_on && mode_lanes_a == 8'h00) |=> lane_ser_a == 8'h00;
   endproperty
   a_clk_only: assert property (p_clk_only) else $error("serializer without bit"); // R3

   property p_xa;
      @(posedge clk) disable iff (!rst_sync_b)
      (link_a_extra_lane_enable[2] && sub_up && !channel_power_down[0]) |=> lane_clk_a[2];
   endproperty
   a_xa: assert property (p_xa) else $error("extra lane A clock off"); // R1

   property p_xb;
      @(posedge clk) disable iff (!rst_sync_b)
      (link_b_extra_lane_enable[5] && sub_up && !channel_power_down[1]) |=> lane_clk_b[5];
   endproperty
   a_xb: assert property (p_xb) else $error("extra lane B clock off"); // R2

   property p_ser;
      @(posedge clk) disable iff (!rst_sync_b)
      (link_a_added_serializer_on && link_a_extra_lane_enable[1] && mode_lanes_a[0]
       && sub_up && !channel_power_down[0]) |=> lane_ser_a[1];
   endproperty
   a_ser: assert property (p_ser) else $error("extra serializer off"); // R4

   property p_chain;
      @(posedge clk) disable iff (!rst_sync_b)
      (!ck_a[0]) |=> lane_ser_a[7:1] == 7'h00;
   endproperty
   a_chain: assert property (p_chain) else $error("serializer above gap"); // R9

   property p_lock;
      @(posedge clk) disable iff (!rst_sync_b)
      (wr && link_enable && addr == `ELSH_ADDR_SHM) |=> $stable(sync_header_mode_select);
   endproperty
   a_lock: assert property (p_lock) else $error("write taken while enabled"); // R5

   property p_sw;
      @(posedge clk) disable iff (!rst_sync_b)
      (mode_is_66b && sync_header_content == `ELSH_SHM_FEC) |=> sync_word_sel == ELSH_SW_FEC;
   endproperty
   a_sw: assert property (p_sw) else $error("FEC not selected"); // R10

   property p_8b;
      @(posedge clk) disable iff (!rst_sync_b)
      !mode_is_66b |=> sync_word_sel == ELSH_SW_IDLE;
   endproperty
   a_8b: assert property (p_8b) else $error("sync word used in 8b/10b"); // R11

   property p_cmd;
      @(posedge clk) disable iff (!rst_sync_b)
      1'b1 |=> sync_cmd == 4'h0;
   endproperty
   a_cmd: assert property (p_cmd) else $error("command field nonzero"); // R12

   property p_ser_none;
      @(posedge clk) disable iff (!rst_sync_b)
      (link_b_extra_lane_enable[7:1] == 7'h00) |=> (lane_clk_b & ~$past(mode_lanes_b)) == 8'h00;
   endproperty
   a_ser_none: assert property (p_ser_none) else $error("lane B on beyond mode lanes"); // R14

   c_ramp: cover property (@(posedge clk) disable iff (!rst_sync_b) |lane_ramp);
   c_fec:  cover property (@(posedge clk) disable iff (!rst_sync_b)
                           sync_word_sel == ELSH_SW_FEC);
   c_full: cover property (@(posedge clk) disable iff (!rst_sync_b) !f_in_ready);
   c_late: cover property (@(posedge clk) disable iff (!rst_sync_b) late_write);
   c_gap:  cover property (@(posedge clk) disable iff (!rst_sync_b)
                           lane_clk_a[2] && !lane_clk_a[1] && lane_ser_a[0]);
endmodule // elsh_top

/* verif/elsh_rx_model.sv */
/*
 Behavioural lane-stream receiver standing at the far side of the block.
 Assumes the stream carries an octet ramp; raw active-low reset from the bench.
*/
`timescale 1ns/1ps
module elsh_rx_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Bench control
   input  wire logic        stall,
   input  wire logic        slow,
   // Lane stream
   input  wire logic        strm_valid,
   output logic             strm_ready,
   input  wire logic [7:0]  strm_data,
   // Results
   output logic [15:0]      taken,
   output logic [15:0]      bad
);
   logic [7:0]  next_octet;
   integer      seed_rx;

   initial seed_rx = 32'h9a2c_0471;

   // Ready: held off, prompt, or throttled at random
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         strm_ready <= 1'h0;
      end else begin
         strm_ready <= !stall && (!slow || ($random(seed_rx) & 1));
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         next_octet <= 8'h00;
         taken      <= 16'h0000;
         bad        <= 16'h0000;
      end else if (strm_valid && strm_ready) begin
         if (strm_data !== next_octet) begin
            bad <= bad + 16'h0001;
         end
         next_octet <= strm_data + 8'h01;
         taken      <= taken + 16'h0001;
      end
   end
endmodule // elsh_rx_model

/* verif/extra_lane_sync_header_cfg_test.sv */
/*
 Self-checking bench for the extra-lane and sync-header configuration block.
 Assumes the design package, params header and stream receiver model.
*/
`timescale 1ns/1ps
`include "elsh_params.svh"
module extra_lane_sync_header_cfg_test
   import elsh_pkg::*;
;
   logic        clk, rst_b, wr, rd, link_enable, mode_is_66b, strm_ready, strm_valid;
   logic        stall, slow, rd_seen, chk;
   logic [11:0] addr;
   logic [7:0]  wdata, rdata, mode_lanes_a, mode_lanes_b, strm_data, e8;
   logic [7:0]  lane_clk_a, lane_ser_a, lane_clk_b, lane_ser_b, xa_v, xb_v, shm_v;
   logic [1:0]  channel_power_down;
   logic [3:0]  test_pattern_select, sync_cmd;
   logic [15:0] lane_ramp, taken, bad;
   logic [53:0] e;
   logic [3:0]  tp_tab [4] = '{4'h0, 4'h5, 4'h1, 4'h2};
   elsh_sw_t    sync_word_sel;
   logic [7:0]  rd_q [$];
   logic [53:0] ln_q [$];
   int          checked, miscompares, cycles;
   integer      seed = 32'h9a2c_0471;

   elsh_top elsh_top_inst (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .link_enable(link_enable),
      .channel_power_down(channel_power_down), .mode_is_66b(mode_is_66b),
      .mode_lanes_a(mode_lanes_a), .mode_lanes_b(mode_lanes_b),
      .test_pattern_select(test_pattern_select), .lane_clk_a(lane_clk_a),
      .lane_ser_a(lane_ser_a), .lane_clk_b(lane_clk_b), .lane_ser_b(lane_ser_b),
      .lane_ramp(lane_ramp), .sync_word_sel(sync_word_sel), .sync_cmd(sync_cmd),
      .strm_valid(strm_valid), .strm_ready(strm_ready), .strm_data(strm_data));

   elsh_rx_model elsh_rx_model_inst (.clk(clk), .rst_b(rst_b), .stall(stall), .slow(slow),
      .strm_valid(strm_valid), .strm_ready(strm_ready), .strm_data(strm_data),
      .taken(taken), .bad(bad));

   // Clock, 100 ns period
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         final_report();
      end
   end

   // Expected lane state of one link: clocks, serializers, ramp flags
   function automatic logic [23:0] calc_link(input logic [7:0] m, input logic [7:0] x,
                                              input logic up, input logic [3:0] tp);
      logic [7:0] c, s, r;
      logic       ok;
      c = up ? (m | {x[7:1], 1'h0}) : 8'h00;
      ok = 1'h1;
      for (int n = 0; n < 8; n++) begin
         s[n] = c[n] & (m[n] | (x[`ELSH_SER_BIT] & x[n])) & ok;
         r[n] = s[n] & ~m[n] & (tp == `ELSH_TP_NONE || tp == `ELSH_TP_ALT);
         ok = ok & c[n];
      end
      return {c, s, r};
   endfunction

   task automatic wreg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'h1;
      @(posedge clk);
      wr    <= 1'h0;
   endtask

   task automatic rreg(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'h1;
      rd_q.push_back(exp);
      @(posedge clk);
      rd   <= 1'h0;
   endtask

   // configuration written while the link is disabled
   task automatic cfg(input logic [7:0] a, input logic [7:0] b, input logic [7:0] s);
      wreg(`ELSH_ADDR_XA, a);
      wreg(`ELSH_ADDR_XB, b);
      wreg(`ELSH_ADDR_SHM, s);
      xa_v = a;
      xb_v = b;
      shm_v = s;
   endtask

   task automatic set_ctx(input logic le, input logic [1:0] pd, input logic m66,
                          input logic [7:0] ma, input logic [7:0] mb, input logic [3:0] tp);
      @(posedge clk);
      link_enable         <= le;
      channel_power_down  <= pd;
      mode_is_66b         <= m66;
      mode_lanes_a        <= ma;
      mode_lanes_b        <= mb;
      test_pattern_select <= tp;
   endtask

   task automatic check_lanes();
      logic [23:0] a, b;
      logic [1:0]  sw;
      a = calc_link(mode_lanes_a, xa_v, ~channel_power_down[0], test_pattern_select);
      b = calc_link(mode_lanes_b, xb_v, ~channel_power_down[1], test_pattern_select);
      sw = !mode_is_66b ? ELSH_SW_IDLE :
           (shm_v[1:0] == `ELSH_SHM_FEC) ? ELSH_SW_FEC : ELSH_SW_CRC;
      repeat (3) @(posedge clk);
      ln_q.push_back({a[23:8], b[23:8], b[7:0], a[7:0], sw, 4'h0});
      chk <= 1'h1;
      @(posedge clk);
      chk <= 1'h0;
   endtask

   // Monitor: oldest note compared as each result appears
   always @(posedge clk) begin
      if (rd_seen) begin
         e8 = rd_q.pop_front();
         check("rdata", {8'h00, rdata}, {8'h00, e8});
      end
      if (chk) begin
         e = ln_q.pop_front();
         check("lane_clk_a", {8'h00, lane_clk_a}, {8'h00, e[53:46]});
         check("lane_ser_a", {8'h00, lane_ser_a}, {8'h00, e[45:38]});
         check("lane_clk_b", {8'h00, lane_clk_b}, {8'h00, e[37:30]});
         check("lane_ser_b", {8'h00, lane_ser_b}, {8'h00, e[29:22]});
         check("lane_ramp", lane_ramp, e[21:6]);
         check("sync_word_sel", {14'h0000, sync_word_sel}, {14'h0000, e[5:4]});
         check("sync_cmd", {12'h000, sync_cmd}, {12'h000, e[3:0]});
      end
      rd_seen <= rd;
   end

   // Main sequence
   initial begin
      {rst_b, wr, rd, link_enable, mode_is_66b, stall, slow, chk} = '0;
      {addr, wdata, mode_lanes_a, mode_lanes_b, channel_power_down} = '0;
      test_pattern_select = 4'h0;
      {xa_v, xb_v, shm_v} = '0;
      repeat (3) @(posedge clk);
      rst_b <= 1'h1;
      repeat (4) @(posedge clk);
      rreg(`ELSH_ADDR_XA, `ELSH_RST_XA);
      rreg(`ELSH_ADDR_XB, `ELSH_RST_XB);
      rreg(`ELSH_ADDR_SHM, `ELSH_RST_SHM);
      rreg(12'h0ff, 8'h00);
      rreg(`ELSH_ADDR_CTRL, 8'h02);
      check_lanes();
      $display("test reset_values done");
      for (int i = 0; i < 8; i++) begin
         set_ctx(1'h0, 2'h0, i[2], 8'h00, 8'h00, 4'h1);
         cfg(8'h00, 8'h00, 8'ha8 | 8'(i[1:0]));
         rreg(`ELSH_ADDR_SHM, 8'ha8 | 8'(i[1:0]));
         check_lanes();
      end
      $display("test sync_header done");
      stall <= 1'h1;
      set_ctx(1'h0, 2'h0, 1'h1, 8'h01, 8'h00, `ELSH_TP_NONE);
      cfg(8'h03, 8'h00, 8'h00);
      repeat (40) @(posedge clk);
      check("strm_valid", {15'h0000, strm_valid}, 16'h0001);
      stall <= 1'h0;
      slow  <= 1'h1;
      repeat (80) @(posedge clk);
      check("taken", {15'h0000, taken > 16'h0010}, 16'h0001);
      check("bad", bad, 16'h0000);
      cfg(8'h00, 8'h00, 8'h00);
      $display("test ramp_stream done");
      set_ctx(1'h0, 2'h0, 1'h0, 8'h01, 8'h03, `ELSH_TP_ALT);
      cfg(8'hfe, 8'h00, 8'h00);
      check_lanes();
      cfg(8'hff, 8'h01, 8'h00);
      check_lanes();
      // lane 1 left off starves upper serializers
      cfg(8'h85, 8'h0d, 8'h00);
      check_lanes();
      $display("test directed_lanes done");
      set_ctx(1'h1, 2'h0, 1'h0, 8'h01, 8'h03, `ELSH_TP_ALT);
      wreg(`ELSH_ADDR_XA, 8'h55);
      wreg(`ELSH_ADDR_SHM, 8'h02);
      rreg(`ELSH_ADDR_XA, xa_v);
      rreg(`ELSH_ADDR_SHM, shm_v);
      rreg(`ELSH_ADDR_STAT, 8'h01);
      rreg(`ELSH_ADDR_CTRL, 8'h03);
      wreg(`ELSH_ADDR_STAT, 8'h01);
      rreg(`ELSH_ADDR_STAT, 8'h00);
      check_lanes();
      $display("test locked_write done");
      set_ctx(1'h0, 2'h3, 1'h1, 8'h0f, 8'h0f, `ELSH_TP_NONE);
      cfg(8'hff, 8'hff, 8'h02);
      rreg(`ELSH_ADDR_CTRL, 8'h00);
      check_lanes();
      $display("test power_down done");
      for (int i = 0; i < 12; i++) begin
         set_ctx(1'h0, 2'($random(seed)), 1'h1, 8'h0f >> ($random(seed) & 3),
                 8'h0f >> ($random(seed) & 3), tp_tab[i % 4]);
         cfg(8'($random(seed)), 8'($random(seed)), 8'h00);
         rreg(`ELSH_ADDR_CTRL, {6'h00, channel_power_down != 2'h3, 1'h0});
         check_lanes();
      end
      $display("test random_lanes done");
      repeat (4) @(posedge clk);
      check("bad", bad, 16'h0000);
      final_report();
   end
endmodule // extra_lane_sync_header_cfg_test
